// >>> mdcfg_checker.sv
`timescale 1ns/100ps
module mdcfg_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Watched pins
    input wire logic speed_below_thresh,
    input wire logic [1:0] max_supply_range,
    input wire logic supply_range_bad,
    input wire logic standby_req,
    input wire logic sleep_req,
    input wire logic current_gain_step,
    input wire logic voltage_gain_step,
    input wire logic [10:0] ext_ref_khz,
    input wire logic tickle_fault,
    input wire logic motor_hiz
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence quiet(s);
        !s [*8];
    endsequence
    a_range_flag: assert property (supply_range_bad == (max_supply_range == 2'h3))
        else $error("range flag");
    a_ref_power: assert property ($onehot(ext_ref_khz) && ext_ref_khz >= 11'h008)
        else $error("ref rate");
    a_cur_gain_gap: assert property (current_gain_step |=> quiet(current_gain_step))
        else $error("current steps");
    a_volt_gain_gap: assert property (voltage_gain_step |=> quiet(voltage_gain_step))
        else $error("voltage steps");
    a_lowpower_one: assert property (!(standby_req && sleep_req))
        else $error("two kinds");
    a_lowpower_drop: assert property (!speed_below_thresh |=> !standby_req && !sleep_req)
        else $error("low power");
    a_hiz_held: assert property (motor_hiz |=> motor_hiz)
        else $error("hiz dropped");
    a_hiz_fault: assert property (motor_hiz |-> tickle_fault)
        else $error("hiz alone");
endmodule : mdcfg_checker

bind mdcfg_top mdcfg_checker u_chk (.sys_clk, .nrst, .speed_below_thresh, .max_supply_range,
    .supply_range_bad, .standby_req, .sleep_req, .current_gain_step, .voltage_gain_step,
    .ext_ref_khz, .tickle_fault, .motor_hiz);

// >>> mdcfg_host.sv
`timescale 1ns/100ps
module mdcfg_host (
    // Clock
    input wire logic sys_clk,
    // Bus wires
    input wire logic sda,
    output logic scl = 1'b1,
    output logic sda_low = 1'b0
);
    task automatic hold(input int c);
        repeat (c) @(posedge sys_clk);
        #2;
    endtask : hold
    // Levels last several clocks so the sampler sees each twice
    task automatic bit_io(input logic b, output logic r);
        sda_low = !b;
        hold(2);
        scl = 1'b1;
        hold(3);
        r = sda;
        scl = 1'b0;
        hold(2);
    endtask : bit_io
    task automatic cond(input logic s);
        sda_low = !s;
        hold(2);
        scl = 1'b1;
        hold(3);
        sda_low = s;
        hold(3);
        scl = !s;
        hold(2);
    endtask : cond
    task automatic octet(input logic [8:0] w, output logic [7:0] r);
        logic [8:0] q;
        for (int i = 8; i >= 0; i--) bit_io(w[i], q[i]);
        r = q[8:1];
    endtask : octet
    // A count of zero sends the bare offset; at TICKLE_OFF that is taken as a bus tickle
    task automatic frame(input logic [7:0] off, input logic rd, input int cnt,
        inout logic [31:0] d);
        logic [7:0] r;
        cond(1'b1);
        octet(9'h005, r);
        octet({off, 1'b1}, r);
        if (rd) begin
            cond(1'b1);
            octet(9'h007, r);
        end
        for (int k = 0; k < cnt; k++) begin
            octet({d[8*k+:8] | {8{rd}}, !rd || k == cnt - 1}, r);
            if (rd) d[8*k+:8] = r;
        end
        cond(1'b0);
    endtask : frame
endmodule : mdcfg_host

// >>> mdcfg_pkg.sv
package mdcfg_pkg;
    // Register offsets on the serial target port
    localparam logic [7:0] SETUP_A_OFF = 8'hA6;
    localparam logic [7:0] SETUP_B_OFF = 8'hA8;
    localparam logic [7:0] TICKLE_OFF = 8'hF0;
    localparam logic [7:0] STATUS_OFF = 8'hF2;
    // Values after reset
    localparam logic [31:0] SETUP_A_RST = 32'h0010_0000;
    localparam logic [31:0] SETUP_B_RST = 32'h0000_0000;
    // Field positions in system_setup_a
    localparam int A_PIN_LO = 28;
    localparam int A_ADDR_LO = 20;
    localparam int A_RANGE_LO = 0;
    // Field positions in system_setup_b
    localparam int B_FREQ_LO = 16;
    localparam int B_SLEEP_LO = 14;
    localparam int B_CGAIN = 13;
    localparam int B_VGAIN = 12;
    localparam int B_LPKIND = 11;
    localparam int B_CLKSEL_LO = 9;
    localparam int B_EXTEN = 8;
    localparam int B_RATE_LO = 5;
    localparam int B_WDEN = 4;
    localparam int B_WDINT_LO = 2;
    localparam int B_WDSRC = 1;
    localparam int B_WDRESP = 0;
    // Codes
    localparam logic [1:0] SPEED_FREQ_MODE = 2'h3;
    localparam logic [1:0] CLK_EXT_CODE = 2'h3;
    localparam logic [1:0] RANGE_UNDEF = 2'h3;
    localparam logic [10:0] EXT_RATE_BASE_KHZ = 11'h008;
    // Times and cycle counts
    localparam int unsigned CLK_MHZ = 40;
    localparam int unsigned CYC_PER_MS = 1000 * CLK_MHZ;
    localparam int unsigned SLEEP_US [4] = '{50, 200, 20000, 200000};
    localparam int unsigned SLEEP_CYC [4] = '{SLEEP_US[0] * CLK_MHZ, SLEEP_US[1] * CLK_MHZ,
        SLEEP_US[2] * CLK_MHZ, SLEEP_US[3] * CLK_MHZ};
    localparam int unsigned GAIN_MS = 1;
    localparam int unsigned GAIN_CYC = GAIN_MS * CYC_PER_MS;
    localparam int unsigned WD_GPIO_MS [4] = '{100, 200, 500, 1000};
    localparam int unsigned WD_I2C_MS [4] = '{1000, 2000, 5000, 10000};
    localparam int unsigned WD_GPIO_CYC [4] = '{WD_GPIO_MS[0] * CYC_PER_MS,
        WD_GPIO_MS[1] * CYC_PER_MS, WD_GPIO_MS[2] * CYC_PER_MS, WD_GPIO_MS[3] * CYC_PER_MS};
    localparam int unsigned WD_I2C_CYC [4] = '{WD_I2C_MS[0] * CYC_PER_MS,
        WD_I2C_MS[1] * CYC_PER_MS, WD_I2C_MS[2] * CYC_PER_MS, WD_I2C_MS[3] * CYC_PER_MS};
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_OFFS, ST_OFFS_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
    } mdcfg_i2c_state_type;
endpackage : mdcfg_pkg

// >>> mdcfg_ratio.sv
`timescale 1ns/100ps
module mdcfg_ratio #(
    parameter int W = 15,
    parameter int QW = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    // Request
    input wire logic start,
    input wire logic [W-1:0] num,
    input wire logic [W-1:0] den,
    // Result
    output logic busy,
    output logic done,
    output logic [QW-1:0] quot
);
    logic [W:0] rem_q;
    logic [W:0] rem_sh;
    logic [W-1:0] den_q;
    logic [5:0] left_q;

    assign busy = (left_q != 6'h0);
    assign rem_sh = {rem_q[W-1:0], 1'b0};

    // Fraction num/den in QW bits; at or over full scale it saturates
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rem_q <= '0;
            den_q <= '0;
            left_q <= 6'h0;
            quot <= '0;
            done <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (start && !busy) begin
                if (den == '0 || num >= den) begin
                    quot <= '1;
                    done <= 1'b1;
                end else begin
                    rem_q <= {1'b0, num};
                    den_q <= den;
                    quot <= '0;
                    left_q <= 6'(QW);
                end
            end else if (busy) begin
                if (rem_sh >= {1'b0, den_q}) begin
                    rem_q <= rem_sh - {1'b0, den_q};
                    quot <= {quot[QW-2:0], 1'b1};
                end else begin
                    rem_q <= rem_sh;
                    quot <= {quot[QW-2:0], 1'b0};
                end
                left_q <= left_q - 6'h1;
                done <= (left_q == 6'h1);
            end
        end
    end
endmodule : mdcfg_ratio

// >>> mdcfg_top.sv
`timescale 1ns/100ps
// What this block does
// - Pin field 0 leaves the shared pin unused, 1 to 3 route phase A, B or C sense.
// - Setup A bits 26:20 hold the serial target address.
// - Supply range codes are 15, 30 or 60 V, and 3 is undefined.
// - Frequency mode duty is measured frequency over the full-scale field.
// - Low power follows a below-threshold speed held for the coded time.
// - Auto current gain readjusts the current gain every 1 ms.
// - Auto voltage gain readjusts the voltage gain every 1 ms.
// - The low-power kind bit picks standby for 0, sleep for 1.
// - Clock source 0 is internal and 3 is external.
// - One bit turns external clock mode on.
// - The rate field gives 8 kHz doubling per code to 1024 kHz.
// - One bit enables the tickle watchdog.
// - Intervals are 100 to 1000 ms on the pin, 1 to 10 s over the bus.
// - The tickle source bit picks bus writes for 0, the pin for 1.
// - Fault response 0 only reports, 1 latches and floats the motor outputs.
// - The full-scale ratio applies only in speed mode 3.
module mdcfg_top
#(
    parameter int unsigned SLEEP_T_CYC [4] = mdcfg_pkg::SLEEP_CYC,
    parameter int unsigned GAIN_T_CYC = mdcfg_pkg::GAIN_CYC,
    parameter int unsigned WD_GPIO_T_CYC [4] = mdcfg_pkg::WD_GPIO_CYC,
    parameter int unsigned WD_I2C_T_CYC [4] = mdcfg_pkg::WD_I2C_CYC,
    parameter int DUTY_W = 16
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    // Serial target pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Phase sense sources and routed pin
    input wire logic phase_a_sense_out,
    input wire logic phase_b_sense_out,
    input wire logic phase_c_sense_out,
    output logic multi_pin_out,
    // Speed input
    input wire logic [1:0] speed_pin_mode,
    input wire logic [14:0] speed_freq,
    input wire logic speed_freq_stb,
    input wire logic speed_below_thresh,
    output logic [DUTY_W-1:0] duty_cmd,
    output logic duty_cmd_stb,
    // Power and gain control
    output logic [1:0] max_supply_range,
    output logic supply_range_bad,
    output logic standby_req,
    output logic sleep_req,
    output logic current_gain_step,
    output logic voltage_gain_step,
    // Clocking
    output logic ext_clk_select,
    output logic clk_sel_bad,
    output logic [10:0] ext_ref_khz,
    // Watchdog
    input wire logic tickle_gpio,
    output logic tickle_fault,
    output logic motor_hiz
);
    import mdcfg_pkg::*;

    mdcfg_i2c_state_type state_q;
    logic [31:0] system_setup_a_q;
    logic [31:0] system_setup_b_q;
    logic scl_q;
    logic sda_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [3:0] bit_cnt_q;
    logic [1:0] idx_q;
    logic [7:0] offset_q;
    logic [23:0] wbuf_q;
    logic nack_q;
    logic wr_stb_q;
    logic [31:0] wr_data_q;
    logic bus_tickle_q;
    logic gpio_q;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [6:0] my_addr;
    logic [23:0] sleep_cnt_q;
    logic [15:0] gain_cnt_q;
    logic gain_tick;
    logic div_busy;
    logic div_done;
    logic [DUTY_W-1:0] div_quot;
    logic [7:0] rd_first;
    logic [7:0] rd_next;

    mdcfg_wd_if wd ();

    // Byte of the word at the current offset; unmapped offsets read as zero
    function automatic logic [7:0] rd_byte(input logic [1:0] idx);
        logic [31:0] w;
        w = 32'h0;
        if (offset_q == SETUP_A_OFF) begin
            w = system_setup_a_q;
        end else if (offset_q == SETUP_B_OFF) begin
            w = system_setup_b_q;
        end else if (offset_q == STATUS_OFF) begin
            w = {28'h0, sleep_req, standby_req, motor_hiz, tickle_fault};
        end
        return w[{idx, 3'h0} +: 8];
    endfunction : rd_byte

    always_comb begin
        rd_first = rd_byte(2'h0);
        rd_next = rd_byte(idx_q + 2'h1);
    end

    assign my_addr = system_setup_a_q[A_ADDR_LO +: 7];
    assign scl_rise = scl_in && !scl_q;
    assign scl_fall = !scl_in && scl_q;
    assign start_cond = scl_in && scl_q && sda_q && !sda_in;
    assign stop_cond = scl_in && scl_q && !sda_q && sda_in;
    assign sda_out = 1'b0;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            gpio_q <= 1'b0;
        end else if (ce) begin
            scl_q <= scl_in;
            sda_q <= sda_in;
            gpio_q <= tickle_gpio;
        end
    end

    // Serial target: bits are taken on SCL rise, SDA changes only after SCL fall
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            sda_oe_n <= 1'b1;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            bit_cnt_q <= 4'h0;
            idx_q <= 2'h0;
            offset_q <= 8'h00;
            wbuf_q <= 24'h0;
            nack_q <= 1'b0;
            wr_stb_q <= 1'b0;
            wr_data_q <= 32'h0;
            bus_tickle_q <= 1'b0;
        end else if (ce) begin
            wr_stb_q <= 1'b0;
            bus_tickle_q <= 1'b0;
            if (start_cond) begin
                state_q <= ST_ADDR;
                bit_cnt_q <= 4'h0;
                sda_oe_n <= 1'b1;
            end else if (stop_cond) begin
                state_q <= ST_IDLE;
                sda_oe_n <= 1'b1;
            end else if (scl_rise) begin
                if (state_q == ST_RDATA_ACK) begin
                    nack_q <= sda_in;
                end else if (state_q == ST_ADDR || state_q == ST_OFFS ||
                    state_q == ST_WDATA) begin
                    shift_q <= {shift_q[6:0], sda_in};
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                end
            end else if (scl_fall) begin
                case (state_q)
                    ST_ADDR: begin
                        if (bit_cnt_q == 4'h8) begin
                            if (shift_q[7:1] == my_addr) begin
                                sda_oe_n <= 1'b0;
                                nack_q <= shift_q[0];
                                state_q <= ST_ADDR_ACK;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        bit_cnt_q <= 4'h0;
                        idx_q <= 2'h0;
                        if (nack_q) begin
                            tx_q <= rd_first;
                            sda_oe_n <= rd_first[7];
                            state_q <= ST_RDATA;
                        end else begin
                            sda_oe_n <= 1'b1;
                            state_q <= ST_OFFS;
                        end
                    end
                    ST_OFFS: begin
                        if (bit_cnt_q == 4'h8) begin
                            sda_oe_n <= 1'b0;
                            offset_q <= shift_q;
                            idx_q <= 2'h0;
                            bus_tickle_q <= (shift_q == TICKLE_OFF);
                            state_q <= ST_OFFS_ACK;
                        end
                    end
                    ST_OFFS_ACK, ST_WDATA_ACK: begin
                        sda_oe_n <= 1'b1;
                        bit_cnt_q <= 4'h0;
                        if (state_q == ST_WDATA_ACK) begin
                            idx_q <= idx_q + 2'h1;
                        end
                        state_q <= ST_WDATA;
                    end
                    ST_WDATA: begin
                        if (bit_cnt_q == 4'h8) begin
                            sda_oe_n <= 1'b0;
                            wbuf_q[{idx_q[1:0], 3'h0} +: 8] <= shift_q;
                            if (idx_q == 2'h3) begin
                                wr_stb_q <= 1'b1;
                                wr_data_q <= {shift_q, wbuf_q};
                            end
                            state_q <= ST_WDATA_ACK;
                        end
                    end
                    ST_RDATA: begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == 4'h7) begin
                            sda_oe_n <= 1'b1;
                            state_q <= ST_RDATA_ACK;
                        end else begin
                            sda_oe_n <= tx_q[6];
                            tx_q <= {tx_q[6:0], 1'b0};
                        end
                    end
                    ST_RDATA_ACK: begin
                        bit_cnt_q <= 4'h0;
                        if (nack_q) begin
                            state_q <= ST_IDLE;
                        end else begin
                            tx_q <= rd_next;
                            sda_oe_n <= rd_next[7];
                            idx_q <= idx_q + 2'h1;
                            state_q <= ST_RDATA;
                        end
                    end
                    default: begin
                        sda_oe_n <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Configuration words; writes to other offsets are acknowledged and dropped
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            system_setup_a_q <= SETUP_A_RST;
            system_setup_b_q <= SETUP_B_RST;
        end else if (ce && wr_stb_q) begin
            if (offset_q == SETUP_A_OFF) begin
                system_setup_a_q <= wr_data_q;
            end else if (offset_q == SETUP_B_OFF) begin
                system_setup_b_q <= wr_data_q;
            end
        end
    end

    // Decoded configuration outputs
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            multi_pin_out <= 1'b0;
            max_supply_range <= 2'h0;
            supply_range_bad <= 1'b0;
            ext_clk_select <= 1'b0;
            clk_sel_bad <= 1'b0;
            ext_ref_khz <= EXT_RATE_BASE_KHZ;
        end else if (ce) begin
            case (system_setup_a_q[A_PIN_LO +: 2])
                2'h1: multi_pin_out <= phase_a_sense_out;
                2'h2: multi_pin_out <= phase_b_sense_out;
                2'h3: multi_pin_out <= phase_c_sense_out;
                default: multi_pin_out <= 1'b0;
            endcase
            max_supply_range <= system_setup_a_q[A_RANGE_LO +: 2];
            supply_range_bad <= (system_setup_a_q[A_RANGE_LO +: 2] == RANGE_UNDEF);
            // Both the source code and the enable are needed
            ext_clk_select <= (system_setup_b_q[B_CLKSEL_LO +: 2] == CLK_EXT_CODE) &&
                system_setup_b_q[B_EXTEN];
            clk_sel_bad <= (system_setup_b_q[B_CLKSEL_LO +: 2] != 2'h0) &&
                (system_setup_b_q[B_CLKSEL_LO +: 2] != CLK_EXT_CODE);
            ext_ref_khz <= EXT_RATE_BASE_KHZ << system_setup_b_q[B_RATE_LO +: 3];
        end
    end

    // Low-power entry timer; any return above threshold restarts it
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sleep_cnt_q <= 24'h0;
            standby_req <= 1'b0;
            sleep_req <= 1'b0;
        end else if (ce) begin
            if (!speed_below_thresh) begin
                sleep_cnt_q <= 24'h0;
                standby_req <= 1'b0;
                sleep_req <= 1'b0;
            end else if (32'(sleep_cnt_q) + 32'h1 >=
                SLEEP_T_CYC[system_setup_b_q[B_SLEEP_LO +: 2]]) begin
                standby_req <= !system_setup_b_q[B_LPKIND];
                sleep_req <= system_setup_b_q[B_LPKIND];
            end else begin
                sleep_cnt_q <= sleep_cnt_q + 24'h1;
            end
        end
    end

    // Shared 1 ms base for both gain loops
    assign gain_tick = (32'(gain_cnt_q) == GAIN_T_CYC - 32'h1);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            gain_cnt_q <= 16'h0;
            current_gain_step <= 1'b0;
            voltage_gain_step <= 1'b0;
        end else if (ce) begin
            gain_cnt_q <= gain_tick ? 16'h0 : gain_cnt_q + 16'h1;
            current_gain_step <= gain_tick && system_setup_b_q[B_CGAIN];
            voltage_gain_step <= gain_tick && system_setup_b_q[B_VGAIN];
        end
    end

    // Samples arriving while a division runs are dropped, not queued
    mdcfg_ratio #(.W(15), .QW(DUTY_W)) u_ratio (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .ce(ce),
        .start(speed_freq_stb && speed_pin_mode == SPEED_FREQ_MODE),
        .num(speed_freq),
        .den(system_setup_b_q[B_FREQ_LO +: 15]),
        .busy(div_busy),
        .done(div_done),
        .quot(div_quot)
    );

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            duty_cmd <= '0;
            duty_cmd_stb <= 1'b0;
        end else if (ce) begin
            duty_cmd_stb <= div_done;
            if (div_done) begin
                duty_cmd <= div_quot;
            end
        end
    end

    assign wd.enable = system_setup_b_q[B_WDEN];
    assign wd.src_gpio = system_setup_b_q[B_WDSRC];
    assign wd.fault_latch = system_setup_b_q[B_WDRESP];
    assign wd.interval = system_setup_b_q[B_WDINT_LO +: 2];
    // Only the selected source counts as a tickle
    assign wd.tickle = system_setup_b_q[B_WDSRC] ? (tickle_gpio && !gpio_q) :
        bus_tickle_q;
    assign tickle_fault = wd.fault;
    assign motor_hiz = wd.hiz;

    mdcfg_wdog #(.GPIO_CYC(WD_GPIO_T_CYC), .I2C_CYC(WD_I2C_T_CYC)) u_wdog (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .ce(ce),
        .wd(wd)
    );
endmodule : mdcfg_top

// >>> mdcfg_top_bench.sv
`timescale 1ns/100ps
module mdcfg_top_bench;
    import mdcfg_pkg::*;
    logic sys_clk, nrst, ce, scl_in, sda_in, sda_oe_n, sda_low, multi_pin_out, tickle_gpio;
    logic phase_a_sense_out, phase_b_sense_out, phase_c_sense_out, speed_freq_stb;
    logic speed_below_thresh, duty_cmd_stb, supply_range_bad, standby_req, sleep_req;
    logic current_gain_step, voltage_gain_step, ext_clk_select, clk_sel_bad, tickle_fault;
    logic motor_hiz;
    logic [1:0] speed_pin_mode, max_supply_range;
    logic [14:0] speed_freq;
    logic [15:0] duty_cmd;
    logic [10:0] ext_ref_khz;
    logic [31:0] v;
    int num_errors = 0;
    int checks_done = 0;
    int n;
    assign sda_in = !(sda_low | !sda_oe_n);
    mdcfg_host host (.sys_clk, .sda(sda_in), .scl(scl_in), .sda_low);
    mdcfg_top #(.SLEEP_T_CYC('{4, 8, 16, 32}), .GAIN_T_CYC(20), .WD_GPIO_T_CYC('{50, 60, 70, 80}),
        .WD_I2C_T_CYC('{400, 500, 600, 700})) dut (.sys_clk, .nrst, .ce, .scl_in, .sda_in,
        .sda_out(), .sda_oe_n, .phase_a_sense_out, .phase_b_sense_out, .phase_c_sense_out,
        .multi_pin_out, .speed_pin_mode, .speed_freq, .speed_freq_stb, .speed_below_thresh,
        .duty_cmd, .duty_cmd_stb, .max_supply_range, .supply_range_bad, .standby_req, .sleep_req,
        .current_gain_step, .voltage_gain_step, .ext_clk_select, .clk_sel_bad, .ext_ref_khz,
        .tickle_gpio, .tickle_fault, .motor_hiz);
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [31:0] x);
        v = x;
        host.frame(SETUP_B_OFF, 1'b0, 4, v);
        host.hold(3);
    endtask : wr
    task automatic results();
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = !sys_clk;
    end
    initial begin
        {nrst, ce, speed_freq_stb, speed_below_thresh, tickle_gpio, speed_pin_mode} = 7'h20;
        {phase_a_sense_out, phase_b_sense_out, phase_c_sense_out, speed_freq} = '0;
        host.hold(10);
        nrst = 1'b1;
        host.frame(SETUP_A_OFF, 1'b1, 4, v);
        chk("setup a", v, SETUP_A_RST);
        host.frame(SETUP_B_OFF, 1'b1, 4, v);
        chk("setup b", v, SETUP_B_RST);
        host.frame(8'h10, 1'b1, 4, v);
        chk("unmapped", v, 0);
        for (int k = 0; k < 4; k++) begin
            v = SETUP_A_RST | k << A_PIN_LO | k;
            host.frame(SETUP_A_OFF, 1'b0, 4, v);
            {phase_c_sense_out, phase_b_sense_out, phase_a_sense_out} = k ? 3'h1 << (k - 1) : 3'h7;
            host.hold(3);
            chk("pin", multi_pin_out, k != 0);
            chk("range", {supply_range_bad, max_supply_range}, {k == 3, k[1:0]});
        end
        for (int r = 0; r < 8; r++) begin
            wr(r * 32'h120);
            chk("ref khz", ext_ref_khz, 11'h008 << r);
            chk("clock", {ext_clk_select, clk_sel_bad}, {r == 7, r[2] ^ r[1]});
        end
        $display("config done");
        for (int g = 0; g < 2; g++) begin
            wr(g * 32'h3000);
            n = 0;
            repeat (200) begin
                host.hold(1);
                n += current_gain_step + voltage_gain_step;
            end
            chk("gain steps", n, g * 20);
        end
        for (int m = 0; m < 2; m++) begin
            wr(32'h4000 | m << 11);
            speed_below_thresh = 1'b1;
            host.hold(6);
            chk("early", {sleep_req, standby_req}, 0);
            host.hold(4);
            chk("low power", {sleep_req, standby_req}, m + 1);
            speed_below_thresh = 1'b0;
        end
        wr(32'h0100_0000);
        speed_freq = 15'h0080;
        for (int m = 0; m < 4; m += 3) begin
            speed_pin_mode = m[1:0];
            speed_freq_stb = 1'b1;
            host.hold(1);
            speed_freq_stb = 1'b0;
            for (n = 0; n < 30 && duty_cmd_stb !== 1'b1; n++) host.hold(1);
            chk("duty seen", n < 30, m == 3);
        end
        chk("duty", duty_cmd, 16'h8000);
        $display("speed done");
        wr(32'h10);
        host.hold(300);
        chk("no fault", tickle_fault, 0);
        host.hold(150);
        chk("fault", tickle_fault, 1);
        host.frame(TICKLE_OFF, 1'b0, 0, v);
        chk("report", {motor_hiz, tickle_fault}, 0);
        wr(0);
        host.hold(500);
        chk("off", tickle_fault, 0);
        wr(32'h13);
        repeat (5) begin
            tickle_gpio = 1'b1;
            host.hold(2);
            tickle_gpio = 1'b0;
            host.hold(18);
        end
        chk("pin tickles", tickle_fault, 0);
        host.hold(60);
        chk("latched", {motor_hiz, tickle_fault}, 3);
        host.frame(STATUS_OFF, 1'b1, 4, v);
        chk("status", v, 3);
        ce = 1'b0;
        speed_below_thresh = 1'b1;
        host.hold(40);
        chk("frozen", {motor_hiz, tickle_fault, sleep_req, standby_req}, 12);
        ce = 1'b1;
        $display("watchdog done");
        results();
    end
endmodule : mdcfg_top_bench

// >>> mdcfg_wd_if.sv
`timescale 1ns/100ps
interface mdcfg_wd_if;
    logic enable;
    logic src_gpio;
    logic fault_latch;
    logic [1:0] interval;
    logic tickle;
    logic fault;
    logic hiz;
    modport cfg (output enable, output src_gpio, output fault_latch, output interval,
        output tickle, input fault, input hiz);
    modport timer (input enable, input src_gpio, input fault_latch, input interval,
        input tickle, output fault, output hiz);
endinterface : mdcfg_wd_if

// >>> mdcfg_wdog.sv
`timescale 1ns/100ps
module mdcfg_wdog #(
    parameter int unsigned GPIO_CYC [4] = mdcfg_pkg::WD_GPIO_CYC,
    parameter int unsigned I2C_CYC [4] = mdcfg_pkg::WD_I2C_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    // Configuration and status
    mdcfg_wd_if.timer wd
);
    import mdcfg_pkg::*;
    logic [31:0] cnt_q;
    logic [31:0] limit;
    logic expire;
    logic fault_q;
    logic hiz_q;

    assign limit = wd.src_gpio ? GPIO_CYC[wd.interval] : I2C_CYC[wd.interval];
    assign expire = wd.enable && !wd.tickle && (cnt_q >= limit - 32'h1);
    assign wd.fault = fault_q;
    assign wd.hiz = hiz_q;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 32'h0;
        end else if (ce) begin
            if (!wd.enable || wd.tickle || expire) begin
                cnt_q <= 32'h0;
            end else begin
                cnt_q <= cnt_q + 32'h1;
            end
        end
    end

    // A tickle in the same cycle blocks a new expiry, so the fault clears instead while hiz_q is clear
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fault_q <= 1'b0;
        end else if (ce) begin
            if (expire) begin
                fault_q <= 1'b1;
            end else if ((wd.tickle || !wd.enable) && !hiz_q) begin
                fault_q <= 1'b0;
            end
        end
    end

    // Latched response only leaves through reset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hiz_q <= 1'b0;
        end else if (ce && expire && wd.fault_latch) begin
            hiz_q <= 1'b1;
        end
    end
endmodule : mdcfg_wdog
